// ===== channel_sync_cfg.svh
`ifndef CHANNEL_SYNC_CFG_SVH
`define CHANNEL_SYNC_CFG_SVH

// coefficient store geometry
`define COEF_WORDS 128
`define COEF_W 20
`define SAMPLE_W 16

// register indices (byte address is four times the index)
`define OFS_COEF_LAST 8'h7F
`define OFS_POWERDOWN 8'h80
`define OFS_SOFT_TRIG 8'h81
`define OFS_PIN_TRIG 8'h82
`define OFS_START_HOLD 8'h83
`define OFS_RETUNE_HOLD 8'h84
`define OFS_TUNE_LOW 8'h85
`define OFS_TUNE_HIGH 8'h86
`define OFS_PHASE_OFS 8'h87
`define OFS_OSC_CTRL 8'h88
`define OFS_COEF_OFFSET 8'hA3
`define OFS_FILT_CTRL 8'hA4
`define OFS_ACTIVE_TUNE 8'hB0
`define OFS_STATUS 8'hB1

// field positions
`define FILT_BANK_BIT 8
`define TRIG_START_BIT 0
`define TRIG_RETUNE_BIT 1
`define PIN_FIRST_ONLY_BIT 2
`define OSC_BYPASS_BIT 0
`define OSC_PDITHER_BIT 1
`define OSC_ADITHER_BIT 2
`define OSC_CLEAR_BIT 3
`define OSC_PORT_BIT 6
`define OSC_PIN_LSB 7
`define OSC_RSVD_MASK 9'h030

// reset values
`define RST_POWERDOWN 1'b1

// hold-off counter landmarks
`define HOLD_OFF 16'h0000
`define HOLD_FIRE 16'h0001
`define HOLD_LAST 16'h0002

`endif

// ===== channel_sync_pkg.sv
package channel_sync_pkg;

    // oscillator and input routing controls leaving the block
    typedef struct packed {
        logic bypass;
        logic phase_dither;
        logic amp_dither;
        logic port_b;
    } osc_cfg_t;

    // one sample pair on the channel's I and Q paths
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } iq_t;

    // complete register state of one channel
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic powerdown;
        logic [2:0] pin_ctrl;
        logic [15:0] start_hold;
        logic [15:0] retune_hold;
        logic [31:0] tune_shadow;
        logic [31:0] tune_active;
        logic [15:0] phase_ofs;
        logic [8:0] osc_ctrl;
        logic [10:0] filt_ctrl;
        logic [7:0] coef_ofs;
        logic [15:0] start_cnt;
        logic start_busy;
        logic [15:0] retune_cnt;
        logic retune_busy;
        logic strobe_prev;
        logic first_seen;
        logic realign;
        logic [31:0] acc;
        logic [15:0] phase;
        iq_t iq;
        logic [19:0] coef;
    } sync_state_t;

endpackage

// ===== channel_sync_control.sv
// Operation
// [R1] coefficient window 0x00-0x7F, 128 words 20 bits
// [R2] filter control bit 8 selects second bank
// [R3] one coefficient set serves I and Q
// [R4] both banks addressable for 160-tap filters
// [R5] power-down bit high means low power
// [R6] shared power-down write updates all channels
// [R7] retune trigger runs counter, loads tuning word
// [R8] start trigger runs counter, clears power-down
// [R9] one of four strobe pins monitored
// [R10] pin enables gate start and retune counters
// [R11] start while running realigns filter phase
// [R12] hold-off counters step once per sample clock
// [R13] start hold-off 1 starts immediately
// [R14] start hold-off 0 suppresses start
// [R15] retune hold-off 1 updates immediately
// [R16] retune hold-off 0 suppresses retune
// [R17] control bit 3 clears accumulator on retune
// [R18] control bits 8-7 pick strobe pin
// [R19] control bit 6 picks input port
// [R20] software writes zero to bits 5-4
// [R21] bypass routes A to I, B to Q
// [R22] coefficient offset selects among stored filters
// [R23] port select low A, high B
// [R24] tuning word shadowed until wake or retune
// [R25] retrigger reloads a running counter
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "channel_sync_cfg.svh"

module channel_sync_control #(
    parameter int CHANNEL_ID = 0,
    parameter int COEF_WORDS = `COEF_WORDS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // shared power-down register, one bit per channel
    input wire logic shared_pd_wr_i,
    input wire logic [3:0] shared_pd_i,
    // timing strobe pins
    input wire logic [3:0] strobe_i,
    // input ports
    input wire logic [15:0] port_a_i,
    input wire logic [15:0] port_b_i,
    // filter coefficient fetch
    input wire logic [7:0] coef_addr_i,
    output logic [19:0] coef_o,
    // channel controls and data
    output logic powerdown_o,
    output logic realign_o,
    output logic [31:0] tuning_word_o,
    output logic [15:0] phase_o,
    output channel_sync_pkg::osc_cfg_t osc_cfg_o,
    output channel_sync_pkg::iq_t iq_o
);
    import channel_sync_pkg::*;

    // refuse geometries the decode cannot serve
    if (CHANNEL_ID < 0 || CHANNEL_ID > 3 || COEF_WORDS != 128)
    begin : g_bad_param
        $error("channel_sync_control: unsupported parameters");
    end

    sync_state_t s_reg;
    sync_state_t s_next;

    // two banks of 128 words, bank in the top address bit
    logic [19:0] coef_mem [0:2*COEF_WORDS-1]; // [R1] [R4]

    logic [7:0] idx;
    logic access;
    logic wr_now;
    logic [31:0] wmerge;
    logic [31:0] rd_val;
    logic sel_strobe;
    logic pin_pulse;
    logic start_trig;
    logic retune_trig;
    logic start_fire;
    logic retune_fire;
    logic wake;
    logic [7:0] fetch_addr;

    // byte-lane merge of write data over current contents
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // bus decode; writes land on the edge that shows ack
    assign idx = adr_i[9:2];
    assign access = cyc_i && stb_i;
    assign wr_now = access && we_i && s_reg.ack;

    // selected strobe edge; inputs are already in this clock domain
    assign sel_strobe = strobe_i[s_reg.osc_ctrl[`OSC_PIN_LSB +: 2]]; // [R9] [R18]
    assign pin_pulse = sel_strobe && !s_reg.strobe_prev
        && !(s_reg.pin_ctrl[`PIN_FIRST_ONLY_BIT] && s_reg.first_seen);

    // software and pin triggers merge into one event each
    always_comb
    begin
        start_trig = pin_pulse && s_reg.pin_ctrl[`TRIG_START_BIT]; // [R10]
        retune_trig = pin_pulse && s_reg.pin_ctrl[`TRIG_RETUNE_BIT]; // [R10]
        if (wr_now && idx == `OFS_SOFT_TRIG && sel_i[0])
        begin
            start_trig = start_trig || dat_i[`TRIG_START_BIT]; // [R8]
            retune_trig = retune_trig || dat_i[`TRIG_RETUNE_BIT]; // [R7]
        end
    end

    // counter reaching 1: either loaded as 1 or stepped down to 1
    assign start_fire = (start_trig && s_reg.start_hold == `HOLD_FIRE) // [R13]
        || (!start_trig && s_reg.start_busy && s_reg.start_cnt == `HOLD_LAST);
    assign retune_fire = (retune_trig && s_reg.retune_hold == `HOLD_FIRE) // [R15]
        || (!retune_trig && s_reg.retune_busy && s_reg.retune_cnt == `HOLD_LAST);

    // read mux; unmapped indices read zero
    always_comb
    begin
        wmerge = 32'h0000_0000;
        if (idx <= `OFS_COEF_LAST)
        begin
            rd_val = {12'h000, coef_mem[{s_reg.filt_ctrl[`FILT_BANK_BIT], idx[6:0]}]}; // [R2]
        end
        else if (idx == `OFS_POWERDOWN)
        begin
            rd_val = {31'h0000_0000, s_reg.powerdown};
        end
        else if (idx == `OFS_PIN_TRIG)
        begin
            rd_val = {29'h0000_0000, s_reg.pin_ctrl};
        end
        else if (idx == `OFS_START_HOLD)
        begin
            rd_val = {16'h0000, s_reg.start_hold};
        end
        else if (idx == `OFS_RETUNE_HOLD)
        begin
            rd_val = {16'h0000, s_reg.retune_hold};
        end
        else if (idx == `OFS_TUNE_LOW)
        begin
            rd_val = {16'h0000, s_reg.tune_shadow[15:0]};
        end
        else if (idx == `OFS_TUNE_HIGH)
        begin
            rd_val = {16'h0000, s_reg.tune_shadow[31:16]};
        end
        else if (idx == `OFS_PHASE_OFS)
        begin
            rd_val = {16'h0000, s_reg.phase_ofs};
        end
        else if (idx == `OFS_OSC_CTRL)
        begin
            rd_val = {23'h00_0000, s_reg.osc_ctrl};
        end
        else if (idx == `OFS_COEF_OFFSET)
        begin
            rd_val = {24'h00_0000, s_reg.coef_ofs};
        end
        else if (idx == `OFS_FILT_CTRL)
        begin
            rd_val = {21'h00_0000, s_reg.filt_ctrl};
        end
        else if (idx == `OFS_ACTIVE_TUNE)
        begin
            rd_val = s_reg.tune_active;
        end
        else if (idx == `OFS_STATUS)
        begin
            rd_val = {29'h0000_0000, s_reg.retune_busy, s_reg.start_busy, s_reg.first_seen};
        end
        else
        begin
            rd_val = 32'h0000_0000;
        end
        wmerge = merge(rd_val, dat_i, sel_i);
    end

    // next-state logic for the whole channel
    always_comb
    begin
        s_next = s_reg;
        wake = 1'b0;
        s_next.realign = 1'b0;
        // one wait state: ack rises the cycle after the request, drops after
        s_next.ack = access && !s_reg.ack;
        if (access && !s_reg.ack)
        begin
            s_next.dat = rd_val;
        end
        s_next.strobe_prev = sel_strobe;

        // register writes
        if (wr_now)
        begin
            if (idx == `OFS_POWERDOWN)
            begin
                s_next.powerdown = wmerge[0]; // [R5]
                wake = s_reg.powerdown && !wmerge[0];
            end
            else if (idx == `OFS_PIN_TRIG)
            begin
                s_next.pin_ctrl = wmerge[2:0];
                s_next.first_seen = 1'b0; // rearm first-strobe-only mode
            end
            else if (idx == `OFS_START_HOLD)
            begin
                s_next.start_hold = wmerge[15:0];
            end
            else if (idx == `OFS_RETUNE_HOLD)
            begin
                s_next.retune_hold = wmerge[15:0];
            end
            else if (idx == `OFS_TUNE_LOW)
            begin
                s_next.tune_shadow[15:0] = wmerge[15:0]; // [R24]
            end
            else if (idx == `OFS_TUNE_HIGH)
            begin
                s_next.tune_shadow[31:16] = wmerge[15:0]; // [R24]
            end
            else if (idx == `OFS_PHASE_OFS)
            begin
                s_next.phase_ofs = wmerge[15:0];
            end
            else if (idx == `OFS_OSC_CTRL)
            begin
                // reserved bits are stored as written; software keeps them low
                s_next.osc_ctrl = wmerge[8:0]; // [R20]
            end
            else if (idx == `OFS_COEF_OFFSET)
            begin
                s_next.coef_ofs = wmerge[7:0]; // [R22]
            end
            else if (idx == `OFS_FILT_CTRL)
            begin
                s_next.filt_ctrl = wmerge[10:0]; // [R2]
            end
        end

        // a strobe in the same cycle as a pin register rewrite still counts as seen
        if (pin_pulse)
        begin
            s_next.first_seen = 1'b1;
        end

        // shared register reaches every channel in the same access
        if (shared_pd_wr_i)
        begin
            s_next.powerdown = shared_pd_i[CHANNEL_ID]; // [R6]
            wake = s_reg.powerdown && !shared_pd_i[CHANNEL_ID];
        end

        // start hold-off: a zero value never arms the counter
        if (start_trig)
        begin
            s_next.start_cnt = s_reg.start_hold; // [R25]
            s_next.start_busy = s_reg.start_hold > `HOLD_FIRE; // [R14]
        end
        else if (s_reg.start_busy)
        begin
            s_next.start_cnt = s_reg.start_cnt - 16'h0001; // [R12]
            s_next.start_busy = !start_fire;
        end
        if (start_fire)
        begin
            if (s_next.powerdown)
            begin
                s_next.powerdown = 1'b0; // [R8]
                wake = 1'b1;
            end
            else
            begin
                s_next.realign = 1'b1; // [R11]
            end
        end

        // retune hold-off mirrors the start counter
        if (retune_trig)
        begin
            s_next.retune_cnt = s_reg.retune_hold; // [R25]
            s_next.retune_busy = s_reg.retune_hold > `HOLD_FIRE; // [R16]
        end
        else if (s_reg.retune_busy)
        begin
            s_next.retune_cnt = s_reg.retune_cnt - 16'h0001; // [R12]
            s_next.retune_busy = !retune_fire;
        end

        // phase accumulator advances only while the channel is awake; a retune loads it even while asleep
        if (!s_reg.powerdown)
        begin
            s_next.acc = s_reg.acc + s_reg.tune_active;
        end
        if (retune_fire || wake)
        begin
            s_next.tune_active = s_reg.tune_shadow; // [R7] [R24]
        end
        if (retune_fire)
        begin
            // continuous hop keeps phase; clearing aligns channels hopping together
            s_next.acc = s_reg.osc_ctrl[`OSC_CLEAR_BIT] ? s_reg.tune_shadow // [R17]
                : s_reg.acc + s_reg.tune_shadow;
        end
        s_next.phase = s_reg.acc[31:16] + s_reg.phase_ofs;
        // single fetch feeds both I and Q multipliers
        s_next.coef = coef_mem[fetch_addr]; // [R3] [R4]

        // input routing; bypass overrides port select
        if (s_reg.osc_ctrl[`OSC_BYPASS_BIT])
        begin
            s_next.iq.i = port_a_i; // [R21]
            s_next.iq.q = port_b_i; // [R21]
        end
        else
        begin
            s_next.iq.i = s_reg.osc_ctrl[`OSC_PORT_BIT] ? port_b_i : port_a_i; // [R19] [R23]
            s_next.iq.q = 16'h0000;
        end
        if (s_reg.powerdown)
        begin
            s_next.iq = '0; // [R5]
        end
    end

    // offset added to the fetch index picks one of several stored filters
    assign fetch_addr = coef_addr_i + s_reg.coef_ofs; // [R22]

    // coefficient store: bus writes and the filter fetch port
    always_ff @(posedge clk_i)
    begin
        if (wr_now && idx <= `OFS_COEF_LAST)
        begin
            coef_mem[{s_reg.filt_ctrl[`FILT_BANK_BIT], idx[6:0]}] <= wmerge[19:0]; // [R1] [R2]
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.powerdown <= `RST_POWERDOWN;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign dat_o = s_reg.dat;
    assign ack_o = s_reg.ack;
    assign coef_o = s_reg.coef;
    assign powerdown_o = s_reg.powerdown;
    assign realign_o = s_reg.realign;
    assign tuning_word_o = s_reg.tune_active;
    assign phase_o = s_reg.phase;
    assign iq_o = s_reg.iq;
    assign osc_cfg_o.bypass = s_reg.osc_ctrl[`OSC_BYPASS_BIT];
    assign osc_cfg_o.phase_dither = s_reg.osc_ctrl[`OSC_PDITHER_BIT];
    assign osc_cfg_o.amp_dither = s_reg.osc_ctrl[`OSC_ADITHER_BIT];
    assign osc_cfg_o.port_b = s_reg.osc_ctrl[`OSC_PORT_BIT];

endmodule // channel_sync_control

// ===== channel_sync_control_properties.sv
`timescale 1ns/1ps
module channel_sync_control_properties
    import channel_sync_pkg::*;
#(
    parameter int CHANNEL_ID = 0
) (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // channel side
    input wire logic shared_pd_wr_i,
    input wire logic [3:0] shared_pd_i,
    input wire logic [15:0] port_a_i,
    input wire logic [15:0] port_b_i,
    input wire logic powerdown_o,
    input wire logic realign_o,
    input wire channel_sync_pkg::osc_cfg_t osc_cfg_o,
    input wire channel_sync_pkg::iq_t iq_o
);
    import channel_sync_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req;
    logic [7:0] idx;
    // a request not yet answered
    assign req = cyc_i && stb_i && !ack_o;
    assign idx = adr_i[9:2];

    property p_ack_answer;
        req |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        ack_o |-> $past(cyc_i && stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_read_zero;
        req && !we_i && (idx == 8'h81 || idx == 8'h89) |=> ack_o && dat_o == 32'h0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("trigger or unused read not zero");
    property p_pd_iq;
        powerdown_o && $past(powerdown_o) |-> iq_o == 32'h0;
    endproperty
    a_pd_iq: assert property (p_pd_iq) else $error("samples flow while asleep");
    property p_bypass;
        osc_cfg_o.bypass && $past(osc_cfg_o.bypass) && !powerdown_o && !$past(powerdown_o)
            |-> iq_o == {$past(port_a_i), $past(port_b_i)};
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass routing wrong");
    property p_port_sel;
        !osc_cfg_o.bypass && !$past(osc_cfg_o.bypass) && osc_cfg_o.port_b == $past(osc_cfg_o.port_b)
            && !powerdown_o && !$past(powerdown_o)
            |-> iq_o == {(osc_cfg_o.port_b ? $past(port_b_i) : $past(port_a_i)), 16'h0};
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("input port routing wrong");
    property p_shared_pd;
        shared_pd_wr_i && shared_pd_i[CHANNEL_ID] |=> powerdown_o;
    endproperty
    a_shared_pd: assert property (p_shared_pd) else $error("shared sleep write ignored");
    property p_pd_rise;
        $rose(powerdown_o) |-> $past(shared_pd_wr_i) || $past(ack_o && we_i && idx == 8'h80);
    endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("sleep entered without a write");
    property p_realign_run;
        realign_o |-> !powerdown_o && !$past(powerdown_o);
    endproperty
    a_realign_run: assert property (p_realign_run) else $error("realign while asleep");

    // main scenarios reached
    c_realign: cover property (realign_o);
    c_wake: cover property ($fell(powerdown_o));
    c_bypass: cover property (osc_cfg_o.bypass && !powerdown_o);
    c_shared: cover property (shared_pd_wr_i);
endmodule // channel_sync_control_properties

// ===== channel_sync_control_test.sv
`timescale 1ns/1ps
module channel_sync_control_test;
    import channel_sync_pkg::*;
    // stimulus and observed signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, shared_pd_wr_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'hF, shared_pd_i = 4'h0, strobe_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, tuning_word_o, w, v;
    logic [15:0] port_a_i = 16'h0, port_b_i = 16'h0, phase_o, p;
    logic [7:0] coef_addr_i = 8'h00;
    logic [19:0] coef_o, cx, cy;
    logic [8:0] o;
    logic ack_o, powerdown_o, realign_o;
    osc_cfg_t osc_cfg_o;
    iq_t iq_o;
    logic [31:0] exp_q[$];
    logic [8:0] osc_tab[3] = '{9'h001, 9'h042, 9'h004};
    int bad_count = 0, samples_checked = 0, c1, c, n, realign_n = 0;

    // free-running clock
    always #4 clk_i = ~clk_i;

    channel_sync_control u_channel_sync_control (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .shared_pd_wr_i(shared_pd_wr_i),
        .shared_pd_i(shared_pd_i), .strobe_i(strobe_i), .port_a_i(port_a_i), .port_b_i(port_b_i),
        .coef_addr_i(coef_addr_i), .coef_o(coef_o), .powerdown_o(powerdown_o), .realign_o(realign_o),
        .tuning_word_o(tuning_word_o), .phase_o(phase_o), .osc_cfg_o(osc_cfg_o), .iq_o(iq_o)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checked %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one classic cycle; released only at the edge where ack is seen
    // only the watchdog ends a wait for ack
    task automatic wb(input logic wr_en, input logic [7:0] ix, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr_en;
        sel_i <= 4'hF;
        adr_i <= {ix, 2'h0};
        dat_i <= d;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        wb(1'b1, ix, d);
    endtask

    task automatic rd(input logic [7:0] ix, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, ix, 32'h0);
    endtask

    task automatic shadow(input logic [31:0] t);
        wr(8'h85, t[15:0]);
        wr(8'h86, t[31:16]);
    endtask

    task automatic pulse(input logic [3:0] s, input logic shared);
        @(posedge clk_i);
        strobe_i <= shared ? 4'h0 : s;
        shared_pd_i <= s;
        shared_pd_wr_i <= shared;
        @(posedge clk_i);
        strobe_i <= 4'h0;
        shared_pd_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // bounded wait: 0 wake, 1 tuning word equals t, 2 realign count equals t
    task automatic wait_for(input int what, input logic [31:0] t, output int k);
        k = 0;
        while (k < 40 && (what == 0 ? powerdown_o !== 1'b0 : what == 1 ? tuning_word_o !== t : realign_n != t))
        begin
            @(posedge clk_i);
            k++;
        end
    endtask

    // read answers against the oldest expectation
    always @(posedge clk_i)
        if (ack_o === 1'b1 && !we_i && exp_q.size() > 0)
            check(dat_o, exp_q.pop_front());

    // realign stands one cycle only; counting it keeps later waits from missing it
    always @(posedge clk_i)
        if (realign_o === 1'b1)
            realign_n++;

    initial
    begin
        void'($urandom(5));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        check(powerdown_o, 1'h1);
        rd(8'h80, 1'h1);
        wr(8'h88, 32'hFFFFFFCF);
        rd(8'h88, 9'h1CF);
        wr(8'h83, 1'h0);
        wr(8'h84, 1'h0);
        wr(8'h81, 2'h3);
        rd(8'h81, 1'h0);
        rd(8'h89, 1'h0);
        repeat (20) @(posedge clk_i);
        check(powerdown_o, 1'h1);
        check(tuning_word_o, 1'h0);
        wr(8'h88, 1'h0);
        $display("registers done");
        w = $urandom;
        shadow(w);
        check(tuning_word_o, 1'h0);
        wr(8'h83, 1'h1);
        wr(8'h81, 1'h1);
        wait_for(0, 0, c1);
        check(c1 < 3, 1'h1);
        check(tuning_word_o, w);
        for (int i = 0; i < 2; i++)
        begin
            n = i ? 6 : 2 + $urandom % 8;
            wr(8'h80, 1'h1);
            wr(8'h83, n);
            wr(8'h81, 1'h1);
            if (i)
            begin
                repeat (2) @(posedge clk_i);
                wr(8'h81, 1'h1);
            end
            wait_for(0, 0, c);
            check(c, c1 + n - 1);
        end
        $display("start done");
        v = $urandom;
        shadow(v);
        wr(8'h84, 1'h0);
        wr(8'h81, 2'h2);
        repeat (20) @(posedge clk_i);
        check(tuning_word_o, w);
        wr(8'h84, 1'h1);
        wr(8'h81, 2'h2);
        wait_for(1, v, c1);
        check(c1 < 3, 1'h1);
        w = $urandom;
        shadow(w);
        n = 2 + $urandom % 8;
        wr(8'h84, n);
        wr(8'h81, 2'h2);
        wait_for(1, w, c);
        check(c, c1 + n - 1);
        wr(8'h88, 4'h8);
        shadow(32'h00010000);
        wr(8'h84, 1'h1);
        wr(8'h81, 2'h2);
        wait_for(1, 32'h00010000, c);
        repeat (3) @(posedge clk_i);
        p = phase_o;
        check(p < 16'h0010, 1'h1);
        @(posedge clk_i);
        check(16'(phase_o - p), 1'h1);
        $display("retune done");
        wr(8'h88, 9'h100);
        wr(8'h82, 2'h2);
        w = $urandom;
        shadow(w);
        pulse(4'hB, 1'b0);
        repeat (10) @(posedge clk_i);
        check(tuning_word_o, 32'h00010000);
        pulse(4'h4, 1'b0);
        wait_for(1, w, c);
        check(c < 10, 1'h1);
        wr(8'h82, 1'h1);
        wr(8'h83, 1'h1);
        n = realign_n;
        pulse(4'h4, 1'b0);
        wait_for(2, n + 1, c);
        check(c < 10, 1'h1);
        check(powerdown_o, 1'h0);
        wr(8'h82, 3'h6);
        pulse(4'h4, 1'b0);
        shadow(v);
        pulse(4'h4, 1'b0);
        check(tuning_word_o, w);
        $display("pins done");
        for (int i = 0; i < 3; i++)
        begin
            o = osc_tab[i];
            wr(8'h88, o);
            port_a_i <= 16'($urandom);
            port_b_i <= 16'($urandom);
            repeat (3) @(posedge clk_i);
            check(iq_o, o[0] ? {port_a_i, port_b_i} : {(o[6] ? port_b_i : port_a_i), 16'h0});
            check(osc_cfg_o, {o[0], o[1], o[2], o[6]});
        end
        $display("routing done");
        cx = 20'($urandom);
        cy = 20'($urandom);
        wr(8'h7F, cx);
        wr(8'hA4, 9'h100);
        wr(8'h7F, cy);
        rd(8'h7F, cy);
        wr(8'hA4, 1'h0);
        rd(8'h7F, cx);
        coef_addr_i <= 8'hFF;
        repeat (2) @(posedge clk_i);
        check(coef_o, cy);
        coef_addr_i <= 8'h7F;
        repeat (2) @(posedge clk_i);
        check(coef_o, cx);
        wr(8'hA3, 8'h7A);
        coef_addr_i <= 8'h05;
        repeat (2) @(posedge clk_i);
        check(coef_o, cx);
        $display("coefficients done");
        pulse(4'h1, 1'b1);
        check(powerdown_o, 1'h1);
        rd(8'h80, 1'h1);
        pulse(4'hE, 1'b1);
        check(powerdown_o, 1'h0);
        $display("shared sleep done");
        summarize();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        bad_count++;
        summarize();
    end
endmodule // channel_sync_control_test

bind channel_sync_control channel_sync_control_properties #(.CHANNEL_ID(CHANNEL_ID)) u_channel_sync_control_properties (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .shared_pd_wr_i(shared_pd_wr_i), .shared_pd_i(shared_pd_i),
    .port_a_i(port_a_i), .port_b_i(port_b_i), .powerdown_o(powerdown_o), .realign_o(realign_o),
    .osc_cfg_o(osc_cfg_o), .iq_o(iq_o)
);
